// ===== dv/line_output_mixer_checker.sv
// Purpose: Port assertions for the line output mixer register bank
// Assumes: One clk domain, rst_n asynchronous and active low
// Notes:   Status checks skip the first edge after release, when the flop still holds reset
`timescale 1ns/10ps
`default_nettype none
module line_output_mixer_checker #(
  parameter int MONO_SOURCES = 6,
  parameter int LEFT_SOURCES = 5
) (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // Register access port
  input wire logic                        reg_write,
  input wire logic                        reg_read,
  input wire logic [7:0]                  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        reg_rvalid,
  input wire logic                        reg_fault,
  // Status inputs
  input wire logic                        mono_gain_pending_in,
  input wire logic                        mono_powered_in,
  // Mixer controls
  input wire logic [MONO_SOURCES-1:0]     mono_route_en,
  input wire logic [MONO_SOURCES*7-1:0]   mono_route_code,
  input wire logic [3:0]                  mono_level,
  input wire logic                        mono_unmute,
  input wire logic [LEFT_SOURCES-1:0]     left_route_en,
  input wire logic [LEFT_SOURCES*7-1:0]   left_route_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_lvl = reg_read && reg_addr == 8'h4F;
  wire wr_lvl = reg_write && reg_addr == 8'h4F;
  a_level_legal: assert property (mono_level <= 4'h9)
    else $error("mono level above 9");
  a_bad_level: assert property (wr_lvl && reg_wdata[7:4] > 4'h9 |=> reg_fault && $stable(mono_level))
    else $error("reserved level code not refused");
  a_mute_write: assert property (wr_lvl |=> mono_unmute == $past(reg_wdata[3]))
    else $error("mute control not written");
  a_reserved_zero: assert property (rd_lvl |=> reg_rvalid && !reg_rdata[2])
    else $error("reserved level bit not zero");
  a_pending_read: assert property ($past(rst_n) && rd_lvl |=> reg_rdata[1] == $past(mono_gain_pending_in, 2))
    else $error("pending bit does not follow input");
  a_powered_read: assert property ($past(rst_n) && rd_lvl |=> reg_rdata[0] == $past(mono_powered_in, 2))
    else $error("powered bit does not follow input");
  a_mono_first: assert property (reg_write && reg_addr == 8'h49 |=> {mono_route_en[0], mono_route_code[6:0]} == $past(reg_wdata))
    else $error("first mono route not stored");
  a_mono_last: assert property (reg_write && reg_addr == 8'h4E |=> {mono_route_en[5], mono_route_code[41:35]} == $past(reg_wdata))
    else $error("last mono route not stored");
  a_left_last: assert property (reg_write && reg_addr == 8'h54 |=> {left_route_en[4], left_route_code[34:28]} == $past(reg_wdata))
    else $error("last left route not stored");
  a_left_hold: assert property (!(reg_write && reg_addr == 8'h50) |=> $stable(left_route_en[0]))
    else $error("left route enable changed without write");
  c_level_read: cover property (rd_lvl);
  c_bad_level: cover property (wr_lvl && reg_wdata[7:4] > 4'h9);
  c_left_write: cover property (reg_write && reg_addr == 8'h54);
endmodule : line_output_mixer_checker
`default_nettype wire

// ===== dv/line_output_mixer_regs_tb.sv
// Purpose: Self-checking bench for the line output mixer register bank
// Assumes: Inputs change at the falling edge, outputs read a half cycle after the rising edge
// Notes:   A byte array per offset models the registers; status bits come from pend and pow
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module line_output_mixer_regs_tb;
  logic clk, rst_n, reg_write, reg_read, reg_rvalid, reg_fault, pend, pow, mono_unmute;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [5:0] mono_route_en;
  logic [41:0] mono_route_code;
  logic [3:0] mono_level;
  logic [4:0] left_route_en;
  logic [34:0] left_route_code;
  logic [7:0] mdl [8'h49:8'h54];
  int n_mismatch, n_tests, cycles;
  logic [7:0] unmapped [4] = '{8'h48, 8'h55, 8'hFF, 8'h00};
  line_output_mixer_regs line_output_mixer_regs_inst (.clk(clk), .rst_n(rst_n),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_fault(reg_fault),
    .mono_gain_pending_in(pend), .mono_powered_in(pow), .mono_route_en(mono_route_en),
    .mono_route_code(mono_route_code), .mono_level(mono_level), .mono_unmute(mono_unmute),
    .left_route_en(left_route_en), .left_route_code(left_route_code));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic chk_out;
    for (int i = 0; i < 6; i++) begin
      `CHK("mono_en", mdl[8'h49+i][7], mono_route_en[i]);
      `CHK("mono_code", mdl[8'h49+i][6:0], mono_route_code[i*7 +: 7]);
    end
    for (int i = 0; i < 5; i++) begin
      `CHK("left_en", mdl[8'h50+i][7], left_route_en[i]);
      `CHK("left_code", mdl[8'h50+i][6:0], left_route_code[i*7 +: 7]);
    end
    `CHK("level", mdl[8'h4F][7:4], mono_level);
    `CHK("unmute", mdl[8'h4F][3], mono_unmute);
  endtask : chk_out
  // Strobes stay up between back-to-back calls; each call sets both, once per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic f;
    f = !(a inside {[8'h49:8'h54]}) || (a == 8'h4F && d[7:4] > 4'h9);
    if (a == 8'h4F) mdl[a] = {(f ? mdl[a][7:4] : d[7:4]), d[3], 3'h0};
    else if (!f) mdl[a] = d;
    reg_write = 1'b1;
    reg_read = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    `CHK("wr_fault", f, reg_fault);
    `CHK("wr_rvalid", 1'b0, reg_rvalid);
    chk_out();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    logic f;
    f = !(a inside {[8'h49:8'h54]});
    e = f ? 8'h00 : (a == 8'h4F) ? {mdl[a][7:3], 1'b0, pend, pow} : mdl[a];
    reg_read = 1'b1;
    reg_write = 1'b0;
    reg_addr = a;
    @(negedge clk);
    `CHK("rvalid", 1'b1, reg_rvalid);
    `CHK("rd_fault", f, reg_fault);
    `CHK("rdata", e, reg_rdata);
  endtask : rd
  task automatic do_reset;
    rst_n = 1'b0;
    pend = 1'b1;
    pow = 1'b0;
    foreach (mdl[a]) mdl[a] = 8'h00;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int a = 8'h49; a <= 8'h54; a++) rd(8'(a));
    chk_out();
  endtask : do_reset
  initial begin
    clk = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    void'($urandom(54315));
    do_reset();
    wr(8'h49, 8'hFF);
    wr(8'h54, 8'h7F);
    repeat (4) for (int a = 8'h49; a <= 8'h54; a++) if (a != 8'h4F) wr(8'(a), 8'($urandom));
    for (int a = 8'h49; a <= 8'h54; a++) rd(8'(a));
    // Every level code, legal and reserved, with a random mute bit and random status bits 1..0 that must not stick
    for (int l = 0; l < 16; l++) begin
      wr(8'h4F, {4'(l), 4'($urandom) & 4'hB});
      rd(8'h4F);
    end
    repeat (8) begin
      pend = 1'($urandom);
      pow = 1'($urandom);
      wr(8'h4F, {4'($urandom % 10), 4'h3});
      rd(8'h4F);
    end
    foreach (unmapped[k]) begin
      wr(unmapped[k], 8'($urandom));
      rd(unmapped[k]);
    end
    do_reset();
    report_and_stop();
  end
endmodule : line_output_mixer_regs_tb
bind line_output_mixer_regs line_output_mixer_checker #(.MONO_SOURCES(MONO_SOURCES),
  .LEFT_SOURCES(LEFT_SOURCES)) checker_inst (.clk(clk), .rst_n(rst_n),
  .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_fault(reg_fault),
  .mono_gain_pending_in(mono_gain_pending_in), .mono_powered_in(mono_powered_in),
  .mono_route_en(mono_route_en), .mono_route_code(mono_route_code),
  .mono_level(mono_level), .mono_unmute(mono_unmute),
  .left_route_en(left_route_en), .left_route_code(left_route_code));
`default_nettype wire

// ===== rtl/line_output_mixer_pkg.sv
// Purpose: Shared constants for the line output mixer register bank
// Assumes: 8-bit register addresses and 8-bit register data
// Notes:   Offsets are byte addresses on the codec control port
package line_output_mixer_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 7;
  localparam int LEVEL_W = 4;

  // Source counts for each driver
  localparam int MONO_SRC_COUNT = 6;
  localparam int LEFT_SRC_COUNT = 5;
  localparam int ROUTE_COUNT = MONO_SRC_COUNT + LEFT_SRC_COUNT;

  // Register offsets
  localparam logic [ADDR_W-1:0] MONO_ROUTE_LINE_IN_LEFT      = 8'h49;
  localparam logic [ADDR_W-1:0] MONO_ROUTE_AMP_LEFT          = 8'h4A;
  localparam logic [ADDR_W-1:0] MONO_ROUTE_DAC_LEFT          = 8'h4B;
  localparam logic [ADDR_W-1:0] MONO_ROUTE_LINE_IN_RIGHT     = 8'h4C;
  localparam logic [ADDR_W-1:0] MONO_ROUTE_AMP_RIGHT         = 8'h4D;
  localparam logic [ADDR_W-1:0] MONO_ROUTE_DAC_RIGHT         = 8'h4E;
  localparam logic [ADDR_W-1:0] MONO_OUTPUT_LEVEL_CTRL       = 8'h4F;
  localparam logic [ADDR_W-1:0] LEFT_OUT_ROUTE_LINE_IN_LEFT  = 8'h50;
  localparam logic [ADDR_W-1:0] LEFT_OUT_ROUTE_AMP_LEFT      = 8'h51;
  localparam logic [ADDR_W-1:0] LEFT_OUT_ROUTE_DAC_LEFT      = 8'h52;
  localparam logic [ADDR_W-1:0] LEFT_OUT_ROUTE_LINE_IN_RIGHT = 8'h53;
  localparam logic [ADDR_W-1:0] LEFT_OUT_ROUTE_AMP_RIGHT     = 8'h54;

  // Route register fields
  localparam int ROUTE_EN_BIT = 7;
  localparam int CODE_MSB = 6;
  localparam int CODE_LSB = 0;
  localparam logic             ROUTE_EN_RESET = 1'b0;
  localparam logic [CODE_W-1:0] CODE_RESET    = 7'h00;

  // Mono output level register fields
  localparam int LEVEL_MSB = 7;
  localparam int LEVEL_LSB = 4;
  localparam int UNMUTE_BIT = 3;
  localparam int RESERVED_BIT = 2;
  localparam int PENDING_BIT = 1;
  localparam int POWERED_BIT = 0;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX   = 4'h9;
  localparam logic               UNMUTE_RESET = 1'b0;
  localparam logic               PENDING_RESET = 1'b1;
  localparam logic               POWERED_RESET = 1'b0;
  localparam logic               RESERVED_VALUE = 1'b0;

  // Read answer for unmapped offsets
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

endpackage : line_output_mixer_pkg

// ===== rtl/line_output_mixer_regs.sv
// Purpose: Control registers for the mono and left line output mixers
// Assumes: Control port strobes are single-cycle and synchronous to clk
// Notes:   Read data is registered and valid one cycle after the read strobe
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Mono route bit 7 enables source, resets 0
// - Mono route bits 6..0 hold attenuation, reset 0
// - Mono level nibble 0..9 dB, higher codes forbidden
// - Mono bit 3 mute control, 0 mutes
// - Mono bit 1 gain pending, reset 1
// - Mono bit 0 driver powered, reset 0
// - Left route bit 7 enables source, resets 0
// - Left route bits 6..0 hold attenuation, reset 0
module line_output_mixer_regs #(
  parameter int MONO_SOURCES = line_output_mixer_pkg::MONO_SRC_COUNT,
  parameter int LEFT_SOURCES = line_output_mixer_pkg::LEFT_SRC_COUNT
) (
  // Clock and reset
  input  wire logic                                                  clk,
  input  wire logic                                                  rst_n,
  // Register access port
  input  wire logic                                                  reg_write,
  input  wire logic                                                  reg_read,
  input  wire logic [line_output_mixer_pkg::ADDR_W-1:0]              reg_addr,
  input  wire logic [line_output_mixer_pkg::DATA_W-1:0]              reg_wdata,
  output var  logic [line_output_mixer_pkg::DATA_W-1:0]              reg_rdata,
  output var  logic                                                  reg_rvalid,
  output var  logic                                                  reg_fault,
  // Status from the mono driver control
  input  wire logic                                                  mono_gain_pending_in,
  input  wire logic                                                  mono_powered_in,
  // Mono line output mixer controls
  output logic      [MONO_SOURCES-1:0]                               mono_route_en,
  output logic      [MONO_SOURCES*line_output_mixer_pkg::CODE_W-1:0] mono_route_code,
  output var  logic [line_output_mixer_pkg::LEVEL_W-1:0]             mono_level,
  output var  logic                                                  mono_unmute,
  // Left line output mixer controls
  output logic      [LEFT_SOURCES-1:0]                               left_route_en,
  output logic      [LEFT_SOURCES*line_output_mixer_pkg::CODE_W-1:0] left_route_code
);

  localparam int ROUTES = MONO_SOURCES + LEFT_SOURCES;
  localparam int CW = line_output_mixer_pkg::CODE_W;

  // Offsets of every route register, mono sources first
  localparam logic [line_output_mixer_pkg::ADDR_W-1:0] ROUTE_ADDR [ROUTES] = '{
    line_output_mixer_pkg::MONO_ROUTE_LINE_IN_LEFT,
    line_output_mixer_pkg::MONO_ROUTE_AMP_LEFT,
    line_output_mixer_pkg::MONO_ROUTE_DAC_LEFT,
    line_output_mixer_pkg::MONO_ROUTE_LINE_IN_RIGHT,
    line_output_mixer_pkg::MONO_ROUTE_AMP_RIGHT,
    line_output_mixer_pkg::MONO_ROUTE_DAC_RIGHT,
    line_output_mixer_pkg::LEFT_OUT_ROUTE_LINE_IN_LEFT,
    line_output_mixer_pkg::LEFT_OUT_ROUTE_AMP_LEFT,
    line_output_mixer_pkg::LEFT_OUT_ROUTE_DAC_LEFT,
    line_output_mixer_pkg::LEFT_OUT_ROUTE_LINE_IN_RIGHT,
    line_output_mixer_pkg::LEFT_OUT_ROUTE_AMP_RIGHT
  };

  // Decoded strobes and held route fields
  logic [ROUTES-1:0]    route_hit;
  logic [ROUTES-1:0]    route_en_all;
  logic [ROUTES*CW-1:0] route_code_all;
  logic                 level_hit;
  logic                 addr_mapped;
  logic                 level_code_ok;

  // Mono status, sampled from the analog driver control
  logic                 gain_pending;
  logic                 powered;

  // Read path
  logic [line_output_mixer_pkg::DATA_W-1:0] next_rdata;
  logic [line_output_mixer_pkg::DATA_W-1:0] level_readback;
  logic                                     next_fault;

  // Address decode
  always_comb begin
    route_hit = '0;
    for (int i = 0; i < ROUTES; i++) begin
      route_hit[i] = (reg_addr == ROUTE_ADDR[i]);
    end
  end

  assign level_hit   = (reg_addr == line_output_mixer_pkg::MONO_OUTPUT_LEVEL_CTRL);
  assign addr_mapped = level_hit || (|route_hit);

  // Reserved level codes are refused so the analog stage never sees them
  assign level_code_ok =
    (reg_wdata[line_output_mixer_pkg::LEVEL_MSB:line_output_mixer_pkg::LEVEL_LSB]
     <= line_output_mixer_pkg::LEVEL_MAX);

  // Route registers, one instance per source and driver
  // Named instances so each register can be found by its offset name in a netlist
  // Mono line output sources
  route_gain_reg mono_route_line_in_left_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[0]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[0]),
    .atten_code (route_code_all[0*CW +: CW])
  );

  route_gain_reg mono_route_amp_left_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[1]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[1]),
    .atten_code (route_code_all[1*CW +: CW])
  );

  route_gain_reg mono_route_dac_left_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[2]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[2]),
    .atten_code (route_code_all[2*CW +: CW])
  );

  route_gain_reg mono_route_line_in_right_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[3]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[3]),
    .atten_code (route_code_all[3*CW +: CW])
  );

  route_gain_reg mono_route_amp_right_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[4]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[4]),
    .atten_code (route_code_all[4*CW +: CW])
  );

  route_gain_reg mono_route_dac_right_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[5]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[5]),
    .atten_code (route_code_all[5*CW +: CW])
  );

  // Left line output sources
  route_gain_reg left_out_route_line_in_left_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[6]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[6]),
    .atten_code (route_code_all[6*CW +: CW])
  );

  route_gain_reg left_out_route_amp_left_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[7]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[7]),
    .atten_code (route_code_all[7*CW +: CW])
  );

  route_gain_reg left_out_route_dac_left_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[8]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[8]),
    .atten_code (route_code_all[8*CW +: CW])
  );

  route_gain_reg left_out_route_line_in_right_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[9]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[9]),
    .atten_code (route_code_all[9*CW +: CW])
  );

  route_gain_reg left_out_route_amp_right_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .write_en   (reg_write && route_hit[10]),
    .write_data (reg_wdata),
    .route_en   (route_en_all[10]),
    .atten_code (route_code_all[10*CW +: CW])
  );

  // Mono driver controls
  assign mono_route_en   = route_en_all[MONO_SOURCES-1:0];
  assign mono_route_code = route_code_all[MONO_SOURCES*CW-1:0];

  // Left driver controls
  assign left_route_en   = route_en_all[ROUTES-1:MONO_SOURCES];
  assign left_route_code = route_code_all[ROUTES*CW-1:MONO_SOURCES*CW];

  // Mono output level; a refused code leaves the previous level in force
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mono_level <= line_output_mixer_pkg::LEVEL_RESET;
    end else if (reg_write && level_hit && level_code_ok) begin
      mono_level <= reg_wdata[line_output_mixer_pkg::LEVEL_MSB:line_output_mixer_pkg::LEVEL_LSB];
    end
  end

  // Mute is independent of the level check so software can always silence the output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mono_unmute <= line_output_mixer_pkg::UNMUTE_RESET;
    end else if (reg_write && level_hit) begin
      mono_unmute <= reg_wdata[line_output_mixer_pkg::UNMUTE_BIT];
    end
  end

  // Pending reads 1 out of reset until the driver control reports otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_pending <= line_output_mixer_pkg::PENDING_RESET;
    end else begin
      gain_pending <= mono_gain_pending_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powered <= line_output_mixer_pkg::POWERED_RESET;
    end else begin
      powered <= mono_powered_in;
    end
  end

  // Level register as software sees it
  always_comb begin
    level_readback = '0;
    level_readback[line_output_mixer_pkg::LEVEL_MSB:line_output_mixer_pkg::LEVEL_LSB] = mono_level;
    level_readback[line_output_mixer_pkg::UNMUTE_BIT]   = mono_unmute;
    level_readback[line_output_mixer_pkg::RESERVED_BIT] = line_output_mixer_pkg::RESERVED_VALUE;
    level_readback[line_output_mixer_pkg::PENDING_BIT]  = gain_pending;
    level_readback[line_output_mixer_pkg::POWERED_BIT]  = powered;
  end

  // Read multiplexer
  always_comb begin
    next_rdata = line_output_mixer_pkg::UNMAPPED_READ;
    if (level_hit) begin
      next_rdata = level_readback;
    end else begin
      for (int i = 0; i < ROUTES; i++) begin
        if (route_hit[i]) begin
          next_rdata = {route_en_all[i], route_code_all[i*CW +: CW]};
        end
      end
    end
  end

  // Fault flags an unmapped access or a refused level code
  always_comb begin
    next_fault = 1'b0;
    if ((reg_write || reg_read) && !addr_mapped) begin
      next_fault = 1'b1;
    end else if (reg_write && level_hit && !level_code_ok) begin
      next_fault = 1'b1;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= line_output_mixer_pkg::UNMAPPED_READ;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_fault <= 1'b0;
    end else begin
      reg_fault <= next_fault;
    end
  end

endmodule : line_output_mixer_regs

`default_nettype wire

// ===== rtl/route_gain_reg.sv
// Purpose: One source-to-output route register: enable bit and attenuation code
// Assumes: Write strobe already decoded for this register's offset
// Notes:   Code is stored as written; the gain table lives on the analog side
`timescale 1ns/10ps
`default_nettype none

module route_gain_reg (
  // Clock and reset
  input  wire logic                                     clk,
  input  wire logic                                     rst_n,
  // Write side
  input  wire logic                                     write_en,
  input  wire logic [line_output_mixer_pkg::DATA_W-1:0] write_data,
  // Held fields
  output var  logic                                     route_en,
  output var  logic [line_output_mixer_pkg::CODE_W-1:0] atten_code
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      route_en <= line_output_mixer_pkg::ROUTE_EN_RESET;
    end else if (write_en) begin
      route_en <= write_data[line_output_mixer_pkg::ROUTE_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      atten_code <= line_output_mixer_pkg::CODE_RESET;
    end else if (write_en) begin
      atten_code <= write_data[line_output_mixer_pkg::CODE_MSB:line_output_mixer_pkg::CODE_LSB];
    end
  end

endmodule : route_gain_reg

`default_nettype wire
